/* File: src/astc_consts.vh */
// constants for the sample trigger and clock selection control block
// assumes a 32-bit classic wishbone slave at byte addresses, 200 MHz system clock
`ifndef ASTC_CONSTS_VH
`define ASTC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASTC_OFS_CTRL_FIRST   8'h00
`define ASTC_OFS_CTRL_SECOND  8'h04
`define ASTC_OFS_STATUS       8'h08

// ----------------------------------------------------------------
// converter_control_first fields
// ----------------------------------------------------------------
`define ASTC_BIT_ENABLE       0
`define ASTC_BIT_SW_START     1
`define ASTC_BIT_PULSE_SEL    2
`define ASTC_FLD_SHT_LO       4
`define ASTC_FLD_SHT_HI       6
`define ASTC_RST_CTRL_FIRST   32'h0000_0000

// ----------------------------------------------------------------
// converter_control_second fields
// ----------------------------------------------------------------
`define ASTC_FLD_SEQ_LO       0
`define ASTC_FLD_SEQ_HI       1
`define ASTC_FLD_TRIG_LO      2
`define ASTC_FLD_TRIG_HI      3
`define ASTC_FLD_CLK_LO       4
`define ASTC_FLD_CLK_HI       5
`define ASTC_BIT_COMPAT       8
`define ASTC_RST_CTRL_SECOND  32'h0000_0000

// ----------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------
`define ASTC_SEQ_SINGLE       2'h0
`define ASTC_TRIG_SOFTWARE    2'h0
`define ASTC_CLK_INTERNAL     2'h0
`define ASTC_MODE_EXTENDED    1'h0
`define ASTC_MODE_PULSE       1'h1

// ----------------------------------------------------------------
// timing counts in enabled system clock cycles
// ----------------------------------------------------------------
`define ASTC_SAMPLE_BASE      10'h004
`define ASTC_CONV_CYCLES      4'hd

`endif

/* File: src/astc_sample_timer.v */
// sample window and conversion phase sequencer
// assumes start is a one-cycle pulse and hold level is synchronous to clk_sys_in
`timescale 1ns/10ps
`include "astc_consts.vh"

module astc_sample_timer (
  input  wire       clk_sys_in,
  input  wire       arst_n_in,
  input  wire       ce_in,
  input  wire       start_in,
  input  wire       pulse_mode_in,
  input  wire       hold_level_in,
  input  wire [9:0] sample_cycles_in,
  output reg        sampling_out,
  output reg        converting_out,
  output reg        done_out,
  output reg        busy_out
);

  localparam ST_IDLE    = 2'h0;
  localparam ST_SAMPLE  = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg [1:0] state_reg;
  reg [9:0] count_reg;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  // extended mode follows the hold level, pulse mode counts a fixed window
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg      <= ST_IDLE;
      count_reg      <= 10'h000;
      sampling_out   <= 1'b0;
      converting_out <= 1'b0;
      done_out       <= 1'b0;
      busy_out       <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_in) begin
            state_reg    <= ST_SAMPLE;
            count_reg    <= sample_cycles_in - 10'h001;
            sampling_out <= 1'b1;
            busy_out     <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (pulse_mode_in ? (count_reg == 10'h000) : !hold_level_in) begin
            state_reg      <= ST_CONVERT;
            count_reg      <= {6'h00, `ASTC_CONV_CYCLES} - 10'h001;
            sampling_out   <= 1'b0;
            converting_out <= 1'b1;
          end else begin
            count_reg <= count_reg - 10'h001;
          end
        end
        ST_CONVERT: begin
          if (count_reg == 10'h000) begin
            state_reg      <= ST_IDLE;
            converting_out <= 1'b0;
            busy_out       <= 1'b0;
            done_out       <= 1'b1;
          end else begin
            count_reg <= count_reg - 10'h001;
          end
        end
        default: begin
          state_reg      <= ST_IDLE;
          sampling_out   <= 1'b0;
          converting_out <= 1'b0;
          busy_out       <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: src/astc_trigger_ctrl.v */
// top of the sample trigger and clock selection control, with wishbone slave
// assumes timer outputs are synchronous to clk_sys_in and a classic wishbone master
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "astc_consts.vh"

module astc_trigger_ctrl (
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  input  wire        ce_in,
  // classic wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // companion timer outputs
  input  wire [2:0]  timer_out_in,
  // converter side
  output reg  [1:0]  conv_clock_source_select_out,
  output reg         conv_clock_internal_out,
  output wire        sample_switch_out,
  output wire        converting_out,
  output wire        conv_done_out,
  output wire        busy_out
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg        enable_reg;
  reg        sw_start_reg;
  reg        pulse_sel_reg;
  reg [2:0]  sht_reg;
  reg [1:0]  seq_mode_reg;
  reg [1:0]  trig_src_reg;
  reg        compat_reg;
  reg        armed_reg;
  reg [2:0]  timer_prev_reg;
  reg [7:0]  done_count_reg;

  wire       sampling;
  wire       converting;
  wire       done;
  wire       busy;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       bus_req       = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire       bus_wr        = bus_req & wb_we_in;
  wire       hit_first     = (wb_adr_in == `ASTC_OFS_CTRL_FIRST);
  wire       hit_second    = (wb_adr_in == `ASTC_OFS_CTRL_SECOND);
  wire       hit_status    = (wb_adr_in == `ASTC_OFS_STATUS);
  wire       wr_first      = bus_wr & hit_first & wb_sel_in[0];
  wire       wr_second_lo  = bus_wr & hit_second & wb_sel_in[0];
  wire       wr_second_hi  = bus_wr & hit_second & wb_sel_in[1];

  // value the enable bit takes after a write this cycle
  wire       enable_next   = wr_first ? wb_dat_in[`ASTC_BIT_ENABLE] : enable_reg;
  wire       enable_rise   = wr_first & wb_dat_in[`ASTC_BIT_ENABLE] & ~enable_reg;

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  // source 0 is the software start bit, 1 to 3 pick a timer output
  wire       timer_mode    = (trig_src_reg != `ASTC_TRIG_SOFTWARE);
  wire [1:0] timer_idx     = trig_src_reg - 2'h1;
  wire       timer_level   = timer_out_in[timer_idx];
  wire       timer_rise    = timer_out_in[timer_idx] & ~timer_prev_reg[timer_idx];
  wire       single_mode   = (seq_mode_reg == `ASTC_SEQ_SINGLE);

  // the hold level sets the extended window, from timer or start bit
  wire       hold_level    = timer_mode ? timer_level : sw_start_reg;

  // a start is taken only while enabled and armed
  wire       trig_event    = timer_mode ? timer_rise : sw_start_reg;
  wire       start_sample  = trig_event & enable_reg & armed_reg & ~busy;

  // arming: intended on enable rise, compat on a first-register write with enable set, in timer-triggered single mode
  wire       arm_intended  = enable_rise;
  wire       arm_compat    = wr_first & compat_reg & timer_mode & single_mode
                             & wb_dat_in[`ASTC_BIT_ENABLE];
  wire       arm_set       = arm_intended | arm_compat;

  // sample window length for pulse mode, base times a power of two
  wire [9:0] sample_cycles = `ASTC_SAMPLE_BASE << sht_reg;

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  // byte lane 0 holds every control bit of the first register
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enable_reg    <= 1'b0;
      pulse_sel_reg <= `ASTC_MODE_EXTENDED;
      sht_reg       <= 3'h0;
    end else if (ce_in) begin
      if (wr_first) begin
        enable_reg    <= wb_dat_in[`ASTC_BIT_ENABLE];
        pulse_sel_reg <= wb_dat_in[`ASTC_BIT_PULSE_SEL];
        sht_reg       <= wb_dat_in[`ASTC_FLD_SHT_HI:`ASTC_FLD_SHT_LO];
      end
    end
  end

  // second register: sequence mode, trigger source, clock source, compat
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_mode_reg                 <= `ASTC_SEQ_SINGLE;
      trig_src_reg                 <= `ASTC_TRIG_SOFTWARE;
      conv_clock_source_select_out <= `ASTC_CLK_INTERNAL;
      conv_clock_internal_out      <= 1'b1;
      compat_reg                   <= 1'b0;
    end else if (ce_in) begin
      if (wr_second_lo) begin
        seq_mode_reg                 <= wb_dat_in[`ASTC_FLD_SEQ_HI:`ASTC_FLD_SEQ_LO];
        trig_src_reg                 <= wb_dat_in[`ASTC_FLD_TRIG_HI:`ASTC_FLD_TRIG_LO];
        conv_clock_source_select_out <= wb_dat_in[`ASTC_FLD_CLK_HI:`ASTC_FLD_CLK_LO];
        conv_clock_internal_out      <= (wb_dat_in[`ASTC_FLD_CLK_HI:`ASTC_FLD_CLK_LO]
                                         == `ASTC_CLK_INTERNAL);
      end
      if (wr_second_hi) begin
        compat_reg <= wb_dat_in[`ASTC_BIT_COMPAT];
      end
    end
  end

  // ----------------------------------------------------------------
  // software start bit
  // ----------------------------------------------------------------
  // pulse mode clears it once the sample begins; extended mode leaves
  // it to software, since its level is the window itself
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_start_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_first) begin
        sw_start_reg <= wb_dat_in[`ASTC_BIT_SW_START];
      end else if (start_sample && !timer_mode && pulse_sel_reg) begin
        sw_start_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // arm flag
  // ----------------------------------------------------------------
  // a new arm in the same cycle as a start wins over the consume
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed_reg <= 1'b0;
    end else if (ce_in) begin
      if (!enable_next) begin
        armed_reg <= 1'b0;
      end else if (arm_set) begin
        armed_reg <= 1'b1;
      end else if (start_sample && single_mode) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer edge history and conversion counter
  // ----------------------------------------------------------------
  // history is kept per output so a source switch sees no false edge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_timer_hist
      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          timer_prev_reg[gi] <= 1'b0;
        end else if (ce_in) begin
          timer_prev_reg[gi] <= timer_out_in[gi];
        end
      end
    end
  endgenerate

  // wraps at 255, lets software count finished conversions
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_count_reg <= 8'h00;
    end else if (ce_in) begin
      if (done) begin
        done_count_reg <= done_count_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  // one wait state: ack one cycle after the strobe, unmapped reads zero
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        if (hit_first) begin
          wb_dat_out <= {25'h000_0000, sht_reg, 1'b0, pulse_sel_reg,
                         sw_start_reg, enable_reg};
        end else if (hit_second) begin
          wb_dat_out <= {23'h00_0000, compat_reg, 2'h0,
                         conv_clock_source_select_out, trig_src_reg, seq_mode_reg};
        end else if (hit_status) begin
          wb_dat_out <= {16'h0000, done_count_reg, 4'h0,
                         converting, armed_reg, sampling, busy};
        end else begin
          wb_dat_out <= 32'h0000_0000;
        end
      end else begin
        wb_dat_out <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample and conversion sequencer
  // ----------------------------------------------------------------
  astc_sample_timer u_sample_timer (
    .clk_sys_in       (clk_sys_in),
    .arst_n_in        (arst_n_in),
    .ce_in            (ce_in),
    .start_in         (start_sample),
    .pulse_mode_in    (pulse_sel_reg),
    .hold_level_in    (hold_level),
    .sample_cycles_in (sample_cycles),
    .sampling_out     (sampling),
    .converting_out   (converting),
    .done_out         (done),
    .busy_out         (busy)
  );

  // sequencer outputs are flops inside the sequencer
  assign sample_switch_out = sampling;
  assign converting_out    = converting;
  assign conv_done_out     = done;
  assign busy_out          = busy;

endmodule

/* File: test/astc_trigger_ctrl_props.sv */
// checker on the trigger control ports: bus handshake, sample window, conversion
// assumes one clock domain; control shadow is taken from byte lane 0 writes
`timescale 1ns/10ps
module astc_trigger_ctrl_props (
  input wire logic        clk_sys_in,
  input wire logic        arst_n_in,
  input wire logic        ce_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [1:0]  conv_clock_source_select_out,
  input wire logic        conv_clock_internal_out,
  input wire logic        sample_switch_out,
  input wire logic        converting_out,
  input wire logic        conv_done_out,
  input wire logic        busy_out
);
  // ------------------------------------------------------------
  // shadow of enable, mode and code, plus conversion length
  // ------------------------------------------------------------
  logic       en_reg;
  logic       pulse_reg;
  logic [2:0] code_reg;
  logic [4:0] conv_cnt_reg;
  wire        take_wr = ce_in & wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out
                        & (wb_adr_in == 8'h00) & wb_sel_in[0];
  // shadow updates at the edge the slave takes the write
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_reg       <= 1'h0;
      pulse_reg    <= 1'h0;
      code_reg     <= 3'h0;
      conv_cnt_reg <= 5'h00;
    end else begin
      if (take_wr) begin
        en_reg    <= wb_dat_in[0];
        pulse_reg <= wb_dat_in[2];
        code_reg  <= wb_dat_in[6:4];
      end
      // count only enabled edges, a frozen clock must not stretch the figure
      if (!converting_out) conv_cnt_reg <= 5'h00;
      else if (ce_in) conv_cnt_reg <= conv_cnt_reg + 5'h01;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_ack_follows_req: assert property (ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("ack missing after request");
  a_ack_single_cycle: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_read_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  a_clock_internal_flag: assert property (
    conv_clock_internal_out == (conv_clock_source_select_out == 2'h0))
    else $error("internal clock flag wrong");
  a_start_raises_busy: assert property ($rose(sample_switch_out) |-> $rose(busy_out))
    else $error("sample without busy");
  a_disabled_quiet: assert property (!en_reg && !sample_switch_out |=> !sample_switch_out)
    else $error("sample while disabled");
  a_pulse_window: assert property ($rose(sample_switch_out) && pulse_reg && code_reg == 3'h0
    |-> sample_switch_out[*4] ##1 !sample_switch_out)
    else $error("pulse window not four cycles");
  a_conv_follows: assert property ($fell(sample_switch_out) |-> converting_out)
    else $error("conversion not after sample");
  a_conv_length: assert property ($fell(converting_out) |-> conv_cnt_reg == 5'h0d
    && conv_done_out) else $error("conversion length wrong");
  a_done_ends_busy: assert property (conv_done_out && ce_in |-> !busy_out ##1 !conv_done_out)
    else $error("done pulse or busy wrong");
endmodule

/* File: test/astc_timer_model.sv */
// companion timer stand-in: one output goes high for a commanded count of cycles
// assumes commands come one clock wide and never overlap a running pulse
`timescale 1ns/10ps
module astc_timer_model (
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       go_in,
  input  wire logic [1:0] ch_in,
  input  wire logic [7:0] len_in,
  output logic      [2:0] timer_level_out
);
  logic [7:0] left_reg;
  // levels move only on the system edge, so the hold input is synchronous
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      left_reg        <= 8'h00;
      timer_level_out <= 3'h0;
    end else if (go_in) begin
      left_reg        <= len_in - 8'h01;
      timer_level_out <= 3'h1 << (ch_in - 2'h1);
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end else begin
      timer_level_out <= 3'h0;
    end
  end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the sample trigger control: registers, triggers, windows
// assumes the timer model drives the timer inputs and the checker is bound below
`timescale 1ns/10ps
module testbench;
  logic        clk_sys_in = 1'h0, arst_n_in = 1'h0, ce_in = 1'h1, go = 1'h0;
  logic        wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
  logic [7:0]  wb_adr_in = 8'h00, len = 8'h01;
  logic [3:0]  wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0000_0000, wb_dat_out, rd;
  logic [1:0]  conv_clock_source_select_out, ch = 2'h1;
  logic [2:0]  timer_out_in, code;
  logic        wb_ack_out, conv_clock_internal_out, sample_switch_out;
  logic        converting_out, conv_done_out, busy_out;
  int          errors = 0, total_checks = 0, cycles = 0, width, l, done_exp = 0;
  astc_trigger_ctrl astc_trigger_ctrl_inst (.clk_sys_in, .arst_n_in, .ce_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .timer_out_in, .conv_clock_source_select_out, .conv_clock_internal_out,
    .sample_switch_out, .converting_out, .conv_done_out, .busy_out);
  astc_timer_model astc_timer_model_inst (.clk_sys_in, .arst_n_in, .go_in(go), .ch_in(ch),
    .len_in(len), .timer_level_out(timer_out_in));
  // ------------------------------------------------------------
  // clock, hang guard, helpers
  // ------------------------------------------------------------
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // the whole run needs well under this many cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  function automatic int exp_width(input bit pulse, input int cd, input int hl);
    return pulse ? (4 << cd) : hl;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; ack and data are taken at the same edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'h1;
    wb_stb_in <= 1'h1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    // no cycle count assumed here; only the bench timeout ends a hung wait
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'h1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'h0;
    wb_stb_in <= 1'h0;
    wb_we_in  <= 1'h0;
  endtask
  // counts window cycles; fixed span since a refused trigger shows nothing
  task automatic measure();
    width = 0;
    repeat (80) begin
      @(posedge clk_sys_in);
      width += (sample_switch_out === 1'h1);
    end
  endtask
  task automatic fire(input logic [1:0] c, input logic [7:0] hl);
    @(posedge clk_sys_in);
    ch  <= c;
    len <= hl;
    go  <= 1'h1;
    @(posedge clk_sys_in);
    go <= 1'h0;
    measure();
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    width = $urandom(32'he1f7009f);
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    for (int a = 0; a < 16; a += 4) begin
      bus(1'h0, a[7:0], 32'h0000_0000);
      check("reset read", 32'h0000_0000, rd);
    end
    check("reset internal", 1, conv_clock_internal_out);
    bus(1'h1, 8'h0c, 32'hffff_ffff);
    bus(1'h0, 8'h0c, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, rd);
    // a frozen clock enable must leave the block idle and intact
    ce_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    ce_in <= 1'h1;
    for (int c = 0; c < 4; c++) begin
      bus(1'h1, 8'h04, c << 4);
      bus(1'h0, 8'h04, 32'h0000_0000);
      check("clock field", c << 4, rd);
      check("clock select", c, conv_clock_source_select_out);
      check("clock internal", c == 0, conv_clock_internal_out);
    end
    // the timer runs below use the internal clock source
    for (int s = 1; s < 4; s++) begin
      code = $urandom_range(2, 0);
      bus(1'h1, 8'h04, s << 2);
      bus(1'h1, 8'h00, 32'h0000_0000);
      bus(1'h1, 8'h00, 32'h0000_0005 | (code << 4));
      fire((s % 3) + 1, 8'h04);
      check("unselected timer", 0, width);
      fire(s, 8'h04);
      check("pulse window", exp_width(1, code, 4), width);
      fire(s, 8'h04);
      check("single conversion", 0, width);
    end
    bus(1'h1, 8'h00, 32'h0000_0000);
    bus(1'h1, 8'h00, 32'h0000_0001);
    l = $urandom_range(12, 3);
    fire(2'h3, l[7:0]);
    check("extended window", exp_width(0, 0, l), width);
    bus(1'h1, 8'h00, 32'h0000_0011);
    fire(2'h3, 8'h04);
    check("no rearm by write", 0, width);
    bus(1'h1, 8'h04, 32'h0000_010c);
    bus(1'h1, 8'h00, 32'h0000_0021);
    fire(2'h3, 8'h04);
    check("compat rearm", exp_width(0, 0, 4), width);
    // clear enable, rewrite, set again to rearm
    bus(1'h1, 8'h04, 32'h0000_000c);
    bus(1'h1, 8'h00, 32'h0000_0000);
    bus(1'h1, 8'h00, 32'h0000_0004);
    bus(1'h1, 8'h00, 32'h0000_0005);
    fire(2'h3, 8'h04);
    check("rearm window", exp_width(1, 0, 4), width);
    bus(1'h1, 8'h00, 32'h0000_0004);
    fire(2'h3, 8'h04);
    check("disabled trigger", 0, width);
    bus(1'h1, 8'h04, 32'h0000_0000);
    bus(1'h1, 8'h00, 32'h0000_0001);
    bus(1'h1, 8'h00, 32'h0000_0007);
    measure();
    check("software window", exp_width(1, 0, 4), width);
    done_exp = 7;
    bus(1'h0, 8'h08, 32'h0000_0000);
    check("done count", done_exp, rd[15:8]);
    test_done();
  end
endmodule
bind astc_trigger_ctrl astc_trigger_ctrl_props astc_trigger_ctrl_props_inst (.clk_sys_in,
  .arst_n_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
  .wb_dat_out, .wb_ack_out, .conv_clock_source_select_out, .conv_clock_internal_out,
  .sample_switch_out, .converting_out, .conv_done_out, .busy_out);
